// File: crri_core.sv
// Reset initialisation of the core special function registers.
`timescale 1ns/1ns
`include "crri_defs.svh"
// Operation
// - Interrupt wake-up with a global enable copies the program counter to stack top.
// - That wake-up advances the stack pointer to the next entry.
// - That wake-up loads the high or low priority vector.
// - Any wake-up sets the causing bits in the first and third interrupt control registers.
// - Unimplemented bits always read zero.
// - First port bits 6 and 7 read zero unless the oscillator mode frees them.
// - Stack top registers clear on every hard reset, kept on plain wake-up.
// - Power reset keeps stack flags and clears pointer; other hard resets clear all.
// - Low program counter and latches clear on hard resets; plain wake-up advances it by two.
// - Table pointers and table latch clear on hard resets, kept on wake-up.
// - First interrupt control clears bits 7:1, bit 0 kept on non-power resets.
// - Second interrupt control resets to all ones, third to 1100 0000.
// - Product, accumulator and indirect pointer clear on RESET, kept through every reset class.
// - Indirect access addresses hold no state and have no reset value.
// - Watchdog wake-up leaves most registers untouched.
module crri_core
    import crri_pkg::*;
#(
    parameter int PC_W = 21
) (
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire crri_class_t RST_CLASS,
    input  wire crri_wake_t  WAKE,
    input  wire logic        PIN_HI_FREE,
    input  wire logic [7:0]  PORT_IN,
    input  wire crri_bus_t   BUS,
    input  wire logic [7:0]  PIR_IN,
    output logic [7:0]       RDATA,
    output logic [7:0]       PIR_OUT,
    output logic [PC_W-1:0]  PC
);

    // ======================================================================
    // Parameter check.
    if (PC_W != 21) begin : g_pc_w_check
        $error("PC_W must be 21.");
    end

    // ======================================================================
    // Reset class decode.
    logic       power_rst;
    logic       hard_rst;
    logic       wake;
    logic       irq_vec;
    logic [7:0] ica;
    logic [7:0] icb;
    logic [7:0] icc;
    assign power_rst = RESET || (RST_CLASS == CRRI_RC_POWER);
    assign hard_rst  = (RST_CLASS == CRRI_RC_HARD);
    assign wake      = (RST_CLASS == CRRI_RC_WAKE);
    assign irq_vec   = wake && WAKE.by_irq
                       && (ica[`CRRI_ICA_EN_HI] || ica[`CRRI_ICA_EN_LO]);

    function automatic logic wr_at(input crri_bus_t b, input logic [4:0] a);
        wr_at = b.wr && (b.addr == a);
    endfunction : wr_at

    // ======================================================================
    // Return stack top and pointer.
    logic [4:0] top_u;
    logic [7:0] top_h;
    logic [7:0] top_l;
    logic [1:0] stk_flags;
    logic [4:0] stk_ptr;
    always_ff @(posedge CLK) begin
        if (power_rst || hard_rst) begin
            top_u <= 5'h00;
            top_h <= 8'h00;
            top_l <= 8'h00;
        end else if (irq_vec) begin
            top_u <= PC[20:16];
            top_h <= PC[15:8];
            top_l <= PC[7:0];
        end else if (!wake) begin
            if (wr_at(BUS, `CRRI_A_STK_TOP_U)) top_u <= BUS.wdata[4:0];
            if (wr_at(BUS, `CRRI_A_STK_TOP_H)) top_h <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_STK_TOP_L)) top_l <= BUS.wdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            stk_flags <= 2'h0;
            stk_ptr   <= 5'h00;
        end else if (power_rst) begin
            stk_ptr <= 5'h00;
        end else if (hard_rst) begin
            stk_flags <= 2'h0;
            stk_ptr   <= 5'h00;
        end else if (irq_vec) begin
            stk_ptr <= stk_ptr + 5'h01;
        end else if (!wake && wr_at(BUS, `CRRI_A_STKP)) begin
            stk_flags <= BUS.wdata[7:6];
            stk_ptr   <= BUS.wdata[4:0];
        end
    end

    // ======================================================================
    // Program counter, latches and table pointer.
    logic [4:0] lat_u;
    logic [7:0] lat_h;
    logic [5:0] tblu;
    logic [7:0] tblh;
    logic [7:0] tbll;
    logic [7:0] tlat;
    always_ff @(posedge CLK) begin
        if (power_rst || hard_rst) begin
            PC <= '0;
        end else if (irq_vec) begin
            PC <= WAKE.high_prio ? `CRRI_VEC_HIGH : `CRRI_VEC_LOW;
        end else if (wake) begin
            PC <= PC + `CRRI_PC_STEP;
        end else if (wr_at(BUS, `CRRI_A_PC_LOW)) begin
            PC <= {lat_u, lat_h, BUS.wdata};
        end
    end

    always_ff @(posedge CLK) begin
        if (power_rst || hard_rst) begin
            lat_u <= 5'h00;
            lat_h <= 8'h00;
            tblu  <= 6'h00;
            tblh  <= 8'h00;
            tbll  <= 8'h00;
            tlat  <= 8'h00;
        end else if (!wake) begin
            if (wr_at(BUS, `CRRI_A_PC_LAT_U)) lat_u <= BUS.wdata[4:0];
            if (wr_at(BUS, `CRRI_A_PC_LAT_H)) lat_h <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_TBLU)) tblu <= BUS.wdata[5:0];
            if (wr_at(BUS, `CRRI_A_TBLH)) tblh <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_TBLL)) tbll <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_TLAT)) tlat <= BUS.wdata;
        end
    end

    // ======================================================================
    // Interrupt control registers and wake-up source flags.
    logic [7:0] pir;
    always_ff @(posedge CLK) begin
        if (power_rst) begin
            ica <= `CRRI_ICA_RST;
            icb <= `CRRI_ICB_RST;
            icc <= `CRRI_ICC_RST;
        end else if (hard_rst) begin
            ica <= {7'h00, ica[0]};
            icb <= `CRRI_ICB_RST;
            icc <= `CRRI_ICC_RST;
        end else if (wake) begin
            ica <= ica | WAKE.ica_set;
            icc <= icc | WAKE.icc_set;
        end else begin
            if (wr_at(BUS, `CRRI_A_ICA)) ica <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_ICB)) icb <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_ICC)) icc <= BUS.wdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pir <= 8'h00;
        end else begin
            pir <= PIR_IN;
        end
    end
    assign PIR_OUT = pir;

    // ======================================================================
    // Data registers kept through every reset class, reset only by RESET, which clears all but the port direction (loaded to all ones).
    logic [7:0] mul_hi;
    logic [7:0] mul_lo;
    logic [3:0] fsrh;
    logic [7:0] fsrl;
    logic [7:0] acc;
    logic [7:0] plat;
    logic [7:0] pdir;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            mul_hi <= 8'h00;
            mul_lo <= 8'h00;
            fsrh   <= 4'h0;
            fsrl   <= 8'h00;
            acc    <= 8'h00;
            plat   <= 8'h00;
            pdir   <= 8'hFF;
        end else if (!power_rst && !hard_rst && !wake) begin
            if (wr_at(BUS, `CRRI_A_MUL_HI)) mul_hi <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_MUL_LO)) mul_lo <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_FSRH)) fsrh <= BUS.wdata[3:0];
            if (wr_at(BUS, `CRRI_A_FSRL)) fsrl <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_ACC)) acc <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_PLAT)) plat <= BUS.wdata;
            if (wr_at(BUS, `CRRI_A_PDIR)) pdir <= BUS.wdata;
        end
    end

    // ======================================================================
    // Read path, one cycle after the strobe.
    logic [7:0] port_mask;
    logic [7:0] next_rdata;
    assign port_mask = PIN_HI_FREE ? 8'hFF : `CRRI_PORT_HI_MASK;
    always_comb begin
        next_rdata = 8'h00;
        case (BUS.addr)
            `CRRI_A_STK_TOP_U: next_rdata = {3'h0, top_u};
            `CRRI_A_STK_TOP_H: next_rdata = top_h;
            `CRRI_A_STK_TOP_L: next_rdata = top_l;
            `CRRI_A_STKP:      next_rdata = {stk_flags, 1'h0, stk_ptr};
            `CRRI_A_PC_LAT_U:  next_rdata = {3'h0, lat_u};
            `CRRI_A_PC_LAT_H:  next_rdata = lat_h;
            `CRRI_A_PC_LOW:    next_rdata = PC[7:0];
            `CRRI_A_TBLU:      next_rdata = {2'h0, tblu};
            `CRRI_A_TBLH:      next_rdata = tblh;
            `CRRI_A_TBLL:      next_rdata = tbll;
            `CRRI_A_TLAT:      next_rdata = tlat;
            `CRRI_A_MUL_HI:    next_rdata = mul_hi;
            `CRRI_A_MUL_LO:    next_rdata = mul_lo;
            `CRRI_A_ICA:       next_rdata = ica;
            `CRRI_A_ICB:       next_rdata = icb;
            `CRRI_A_ICC:       next_rdata = icc;
            `CRRI_A_FSRH:      next_rdata = {4'h0, fsrh};
            `CRRI_A_FSRL:      next_rdata = fsrl;
            `CRRI_A_ACC:       next_rdata = acc;
            `CRRI_A_PIN:       next_rdata = PORT_IN & port_mask;
            `CRRI_A_PLAT:      next_rdata = plat & port_mask;
            `CRRI_A_PDIR:      next_rdata = pdir & port_mask;
            default:           next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else if (BUS.rd) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ======================================================================
    // Named steps of interrupt and plain wake-ups and of power or hard resets.
    sequence s_irq_wake;
        irq_vec;
    endsequence

    sequence s_plain_wake;
        wake && !irq_vec;
    endsequence

    sequence s_any_reset;
        power_rst || hard_rst;
    endsequence

    sequence s_vector_high;
        PC == `CRRI_VEC_HIGH;
    endsequence

    sequence s_vector_low;
        PC == `CRRI_VEC_LOW;
    endsequence

    // ======================================================================
    // Interrupt wake-up checks.
    a_irq_stack_push: assert property (@(posedge CLK) disable iff (RESET)
        s_irq_wake
        |=> {top_u, top_h, top_l} == $past(PC))
        else $error("Stack top not loaded.");
    a_irq_ptr_step: assert property (@(posedge CLK) disable iff (RESET)
        s_irq_wake
        |=> stk_ptr == $past(stk_ptr) + 5'h01)
        else $error("Pointer not advanced.");
    a_irq_vector: assert property (@(posedge CLK) disable iff (RESET)
        s_irq_wake
        |=> PC == `CRRI_VEC_HIGH || PC == `CRRI_VEC_LOW)
        else $error("Bad vector.");
    a_vector_high_prio: assert property (@(posedge CLK) disable iff (RESET)
        irq_vec && WAKE.high_prio
        |=> s_vector_high)
        else $error("High priority vector missed.");
    a_vector_low_prio: assert property (@(posedge CLK) disable iff (RESET)
        irq_vec && !WAKE.high_prio
        |=> s_vector_low)
        else $error("Low priority vector missed.");

    // ======================================================================
    // Hard and power reset checks.
    a_hard_stack_clr: assert property (@(posedge CLK) disable iff (RESET)
        hard_rst
        |=> top_u == 5'h00 && top_h == 8'h00 && stk_flags == 2'h0)
        else $error("Stack not cleared.");
    a_reset_top_clr: assert property (@(posedge CLK) disable iff (RESET)
        s_any_reset
        |=> top_u == 5'h00 && top_h == 8'h00 && top_l == 8'h00)
        else $error("Stack top not cleared.");
    a_power_flag_keep: assert property (@(posedge CLK) disable iff (RESET)
        power_rst
        |=> stk_flags == $past(stk_flags) && stk_ptr == 5'h00)
        else $error("Flags lost.");
    a_hard_ptr_clr: assert property (@(posedge CLK) disable iff (RESET)
        hard_rst
        |=> stk_ptr == 5'h00)
        else $error("Pointer not cleared.");
    a_reset_pc_clr: assert property (@(posedge CLK) disable iff (RESET)
        s_any_reset
        |=> PC == 21'h000000 && lat_u == 5'h00 && lat_h == 8'h00)
        else $error("Program counter not cleared.");
    a_table_reset_clr: assert property (@(posedge CLK) disable iff (RESET)
        s_any_reset
        |=> tblu == 6'h00 && tblh == 8'h00 && tbll == 8'h00 && tlat == 8'h00)
        else $error("Table not cleared.");
    a_ctrl_reset_vals: assert property (@(posedge CLK) disable iff (RESET)
        hard_rst
        |=> icb == 8'hFF && icc == 8'hC0 && ica[0] == $past(ica[0]))
        else $error("Bad control reset.");
    a_power_ctrl_vals: assert property (@(posedge CLK) disable iff (RESET)
        power_rst
        |=> ica == 8'h00 && icb == 8'hFF && icc == 8'hC0)
        else $error("Bad power control reset.");
    a_hard_ctrl_clr: assert property (@(posedge CLK) disable iff (RESET)
        hard_rst
        |=> ica[7:1] == 7'h00)
        else $error("Control bits not cleared.");

    // ======================================================================
    // Wake-up, flag copy and data retention checks.
    a_wake_pc_step: assert property (@(posedge CLK) disable iff (RESET)
        s_plain_wake
        |=> PC == $past(PC) + 21'h000002)
        else $error("Program counter not advanced.");
    a_wake_top_keep: assert property (@(posedge CLK) disable iff (RESET)
        s_plain_wake
        |=> {top_u, top_h, top_l} == $past({top_u, top_h, top_l}))
        else $error("Stack top changed.");
    a_wake_latch_keep: assert property (@(posedge CLK) disable iff (RESET)
        wake
        |=> lat_u == $past(lat_u) && lat_h == $past(lat_h))
        else $error("Latches changed.");
    a_table_keep_wake: assert property (@(posedge CLK) disable iff (RESET)
        wake
        |=> tblh == $past(tblh) && tlat == $past(tlat))
        else $error("Table changed.");
    a_wake_set_bits: assert property (@(posedge CLK) disable iff (RESET)
        wake |=> (ica & $past(WAKE.ica_set)) == $past(WAKE.ica_set)
            && (icc & $past(WAKE.icc_set)) == $past(WAKE.icc_set))
        else $error("Wake source bits not set.");
    a_flag_copy: assert property (@(posedge CLK) disable iff (RESET)
        !RESET
        |=> PIR_OUT == $past(PIR_IN))
        else $error("Flag copy wrong.");
    a_data_regs_keep: assert property (@(posedge CLK) disable iff (RESET)
        RST_CLASS != CRRI_RC_NONE
        |=> mul_hi == $past(mul_hi) && mul_lo == $past(mul_lo) && acc == $past(acc)
            && fsrh == $past(fsrh) && fsrl == $past(fsrl))
        else $error("Data register changed.");

    // ======================================================================
    // Read path checks.
    a_stack_unimpl_zero: assert property (@(posedge CLK) disable iff (RESET)
        BUS.rd && BUS.addr == `CRRI_A_STKP
        |=> RDATA[5] == 1'h0)
        else $error("Unimplemented bit set.");
    a_indirect_read_zero: assert property (@(posedge CLK) disable iff (RESET)
        BUS.rd && BUS.addr >= `CRRI_A_IND && BUS.addr <= `CRRI_A_PLSW
        |=> RDATA == 8'h00)
        else $error("Indirect address read nonzero.");
    a_port_hi_zero: assert property (@(posedge CLK) disable iff (RESET)
        BUS.rd && BUS.addr == `CRRI_A_PIN && !PIN_HI_FREE
        |=> RDATA[7:6] == 2'h0)
        else $error("Port high bits set.");
    a_latch_hi_zero: assert property (@(posedge CLK) disable iff (RESET)
        BUS.rd && BUS.addr == `CRRI_A_PLAT && !PIN_HI_FREE
        |=> RDATA[7:6] == 2'h0)
        else $error("Latch high bits set.");
endmodule : crri_core

// File: crri_defs.svh
// Offsets, field positions, reset values and vectors of the core reset register bank.
`ifndef CRRI_DEFS_SVH
`define CRRI_DEFS_SVH
`define CRRI_A_STK_TOP_U 5'h00
`define CRRI_A_STK_TOP_H 5'h01
`define CRRI_A_STK_TOP_L 5'h02
`define CRRI_A_STKP     5'h03
`define CRRI_A_PC_LAT_U 5'h04
`define CRRI_A_PC_LAT_H 5'h05
`define CRRI_A_PC_LOW   5'h06
`define CRRI_A_TBLU     5'h07
`define CRRI_A_TBLH     5'h08
`define CRRI_A_TBLL     5'h09
`define CRRI_A_TLAT     5'h0A
`define CRRI_A_MUL_HI   5'h0B
`define CRRI_A_MUL_LO   5'h0C
`define CRRI_A_ICA      5'h0D
`define CRRI_A_ICB      5'h0E
`define CRRI_A_ICC      5'h0F
`define CRRI_A_IND      5'h10
`define CRRI_A_PINC     5'h11
`define CRRI_A_PDEC     5'h12
`define CRRI_A_PREI     5'h13
`define CRRI_A_PLSW     5'h14
`define CRRI_A_FSRH     5'h15
`define CRRI_A_FSRL     5'h16
`define CRRI_A_ACC      5'h17
`define CRRI_A_PIN      5'h18
`define CRRI_A_PLAT     5'h19
`define CRRI_A_PDIR     5'h1A
`define CRRI_ICA_RST    8'h00
`define CRRI_ICB_RST    8'hFF
`define CRRI_ICC_RST    8'hC0
`define CRRI_ICA_EN_HI  7
`define CRRI_ICA_EN_LO  6
`define CRRI_STK_PTR_W  5
`define CRRI_VEC_HIGH   21'h000008
`define CRRI_VEC_LOW    21'h000018
`define CRRI_PC_STEP    21'h000002
`define CRRI_PORT_HI_MASK 8'h3F
`endif

// File: crri_pkg.sv
// Types shared by the core reset register bank.
package crri_pkg;
    typedef enum logic [1:0] {
        CRRI_RC_NONE   = 2'h0,
        CRRI_RC_POWER  = 2'h1,
        CRRI_RC_HARD   = 2'h3,
        CRRI_RC_WAKE   = 2'h2
    } crri_class_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } crri_bus_t;

    typedef struct packed {
        logic       by_irq;
        logic       high_prio;
        logic [7:0] ica_set;
        logic [7:0] icc_set;
    } crri_wake_t;
endpackage : crri_pkg

// File: crri_core_tb.sv
// Self-checking testbench of the core reset register bank.
`timescale 1ns/1ns
`include "crri_defs.svh"
module crri_core_tb;
    import crri_pkg::*;
    // =====================================================================
    // Signals and design.
    logic        clk;
    logic        reset;
    crri_class_t rst_class;
    crri_wake_t  wake;
    logic        pin_hi_free;
    logic [7:0]  port_in;
    crri_bus_t   bus;
    logic [7:0]  pir_in;
    logic [7:0]  rdata;
    logic [7:0]  pir_out;
    logic [20:0] pc;
    int          fail_count;
    int          n_tests;

    crri_core u_dut (
        .CLK         (clk),
        .RESET       (reset),
        .RST_CLASS   (rst_class),
        .WAKE        (wake),
        .PIN_HI_FREE (pin_hi_free),
        .PORT_IN     (port_in),
        .BUS         (bus),
        .PIR_IN      (pir_in),
        .RDATA       (rdata),
        .PIR_OUT     (pir_out),
        .PC          (pc)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // =====================================================================
    // Access tasks.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        check({16'h0000, rdata}, {16'h0000, e});
    endtask : rd

    task automatic pulse(input crri_class_t c, input logic irq, input logic hi,
                         input logic [7:0] sa, input logic [7:0] sc);
        @(posedge clk);
        rst_class <= c;
        wake <= '{by_irq: irq, high_prio: hi, ica_set: sa, icc_set: sc};
        @(posedge clk);
        rst_class <= CRRI_RC_NONE;
        wake <= '0;
        #1;
    endtask : pulse

    function automatic logic [7:0] wmask(input logic [4:0] a);
        case (a)
            5'h00, 5'h04: return 8'h1F;
            5'h07: return 8'h3F;
            5'h15: return 8'h0F;
            5'h10, 5'h11, 5'h12, 5'h13, 5'h14: return 8'h00;
            5'h19, 5'h1A: return 8'h3F;
            default: return 8'hFF;
        endcase
    endfunction : wmask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // =====================================================================
    // Tests.
    initial begin
        #20000;
        fail_count++;
        conclude();
    end

    initial begin
        reset = 1'b1;
        rst_class = CRRI_RC_NONE;
        wake = '0;
        pin_hi_free = 1'b0;
        port_in = 8'hFF;
        bus = '0;
        pir_in = 8'h00;
        fail_count = 0;
        n_tests = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 28; i++) begin
            rd(5'(i), (i == 14) ? 8'hFF : (i == 15) ? 8'hC0 :
               (i == 24 || i == 26) ? 8'h3F : 8'h00);
        end
        for (int i = 0; i < 27; i++) begin
            if (!(i inside {3, 6, 13, 15, 24})) wr(5'(i), 8'hFF);
        end
        for (int i = 0; i < 27; i++) begin
            if (!(i inside {3, 6, 13, 15, 24})) rd(5'(i), wmask(5'(i)));
        end
        @(posedge clk);
        pin_hi_free <= 1'b1;
        wr(`CRRI_A_PLAT, 8'hFF);
        rd(`CRRI_A_PIN, 8'hFF);
        rd(`CRRI_A_PLAT, 8'hFF);
        @(posedge clk);
        pin_hi_free <= 1'b0;
        rd(`CRRI_A_PLAT, 8'h3F);
        wr(`CRRI_A_PC_LAT_U, 8'h01);
        wr(`CRRI_A_PC_LAT_H, 8'h23);
        wr(`CRRI_A_PC_LOW, 8'h44);
        wr(`CRRI_A_ICA, 8'h81);
        pulse(CRRI_RC_WAKE, 1'b0, 1'b0, 8'h04, 8'h01);
        check({3'h0, pc}, 24'h012346);
        rd(`CRRI_A_ICA, 8'h85);
        rd(`CRRI_A_ICC, 8'hC1);
        rd(`CRRI_A_STK_TOP_U, 8'h1F);
        rd(`CRRI_A_TBLU, 8'h3F);
        rd(`CRRI_A_MUL_HI, 8'hFF);
        pulse(CRRI_RC_WAKE, 1'b1, 1'b1, 8'h00, 8'h00);
        check({3'h0, pc}, 24'h000008);
        rd(`CRRI_A_STK_TOP_U, 8'h01);
        rd(`CRRI_A_STK_TOP_H, 8'h23);
        rd(`CRRI_A_STK_TOP_L, 8'h46);
        rd(`CRRI_A_STKP, 8'h01);
        wr(`CRRI_A_ICA, 8'h40);
        pulse(CRRI_RC_WAKE, 1'b1, 1'b0, 8'h00, 8'h00);
        check({3'h0, pc}, 24'h000018);
        rd(`CRRI_A_STK_TOP_L, 8'h08);
        rd(`CRRI_A_STKP, 8'h02);
        wr(`CRRI_A_ICA, 8'h01);
        pulse(CRRI_RC_WAKE, 1'b1, 1'b0, 8'h00, 8'h00);
        check({3'h0, pc}, 24'h00001A);
        rd(`CRRI_A_STKP, 8'h02);
        wr(`CRRI_A_STKP, 8'hFF);
        rd(`CRRI_A_STKP, 8'hDF);
        wr(`CRRI_A_ICB, 8'h00);
        pulse(CRRI_RC_HARD, 1'b0, 1'b0, 8'h00, 8'h00);
        check({3'h0, pc}, 24'h000000);
        rd(`CRRI_A_ICA, 8'h01);
        rd(`CRRI_A_ICB, 8'hFF);
        rd(`CRRI_A_ICC, 8'hC0);
        rd(`CRRI_A_STKP, 8'h00);
        rd(`CRRI_A_STK_TOP_U, 8'h00);
        rd(`CRRI_A_PC_LAT_H, 8'h00);
        rd(`CRRI_A_TBLH, 8'h00);
        rd(`CRRI_A_MUL_LO, 8'hFF);
        rd(`CRRI_A_FSRH, 8'h0F);
        wr(`CRRI_A_TBLL, 8'h55);
        wr(`CRRI_A_STK_TOP_H, 8'h66);
        wr(`CRRI_A_STKP, 8'hC5);
        pulse(CRRI_RC_POWER, 1'b0, 1'b0, 8'h00, 8'h00);
        rd(`CRRI_A_STKP, 8'hC0);
        rd(`CRRI_A_TBLL, 8'h00);
        rd(`CRRI_A_STK_TOP_H, 8'h00);
        rd(`CRRI_A_ACC, 8'hFF);
        rd(`CRRI_A_FSRL, 8'hFF);
        rd(`CRRI_A_PLSW, 8'h00);
        @(posedge clk);
        pir_in <= 8'h5A;
        repeat (2) @(posedge clk);
        #1;
        check({16'h0000, pir_out}, 24'h00005A);
        conclude();
    end
endmodule : crri_core_tb
